// ### requester_request_port.sv
`timescale 1ns/1ps
module requester_request_port
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic request_stream_valid,
    output logic request_stream_ready,
    input wire logic [requester_request_port_pkg::DATA_W-1:0] request_stream_data,
    input wire logic [requester_request_port_pkg::KEEP_W-1:0] request_stream_dword_keep,
    input wire logic request_stream_final_beat,
    input wire logic [requester_request_port_pkg::SIDE_W-1:0] request_sideband_bus,
    output logic link_valid,
    output logic [requester_request_port_pkg::DATA_W-1:0] link_data,
    output logic [requester_request_port_pkg::KEEP_W-1:0] link_dword_keep,
    output logic link_final_beat,
    output logic link_nullify,
    output logic [3:0] link_first_dword_byte_mask,
    output logic [3:0] link_last_dword_byte_mask,
    output logic [2:0] link_payload_offset,
    input wire logic cpl_final_eof_accepted,
    input wire logic [requester_request_port_pkg::TAG_W-1:0] cpl_tag,
    output logic [requester_request_port_pkg::TAG_W-1:0] assigned_tag_out,
    output logic assigned_tag_valid,
    output logic aer_internal_error
);
    import requester_request_port_pkg::*;

    frame_state_t state_q;
    logic ready_q;
    logic first_q;
    logic payload_q;
    logic abort_q;
    logic drop_err_q;
    logic frame_err_q;
    logic [2:0] ctrl_q;
    logic [15:0] null_cnt_q;
    logic [31:0] hrdata_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [CNT_W-1:0] outstanding;
    logic table_full;
    logic accept;
    logic beat_end;
    logic disc_now;
    logic kill_now;
    logic [3:0] req_type;
    logic is_np;
    logic is_msg;
    logic is_atomic;
    logic has_payload;
    logic ext_mode;
    logic blocked;
    logic [31:0] rd_value;

    assign ext_mode = ctrl_q[CTRL_EXT_TAG_BIT];
    assign req_type = request_stream_data[REQ_TYPE_LSB +: 4];
    assign is_msg = (req_type == REQ_MSG) || (req_type == REQ_MSG_VD) || (req_type == REQ_MSG_ATS);
    assign is_atomic = (req_type == REQ_ATOM_ADD) || (req_type == REQ_ATOM_SWAP)
        || (req_type == REQ_ATOM_CAS);
    assign is_np = !is_msg && (req_type != REQ_MEM_WR);
    assign has_payload = (req_type == REQ_MEM_WR) || (req_type == REQ_IO_WR) || is_atomic
        || (req_type == REQ_CFG0_WR) || (req_type == REQ_CFG1_WR) || is_msg;
    assign blocked = is_np && !ext_mode && table_full;
    assign accept = request_stream_valid && ready_q;
    assign beat_end = accept && request_stream_final_beat;
    assign disc_now = accept && request_sideband_bus[DISCONTINUE_BIT];
    // abort only counts for requests that carry a payload
    assign kill_now = (disc_now && (first_q ? has_payload : payload_q)) || abort_q || drop_err_q;

    // packet framing: admit a new packet only when it may enter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
            first_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (request_stream_valid && !blocked)
                    begin
                        state_q <= ST_BODY;
                        ready_q <= 1'b1;
                        first_q <= 1'b1;
                    end
                end
                ST_BODY:
                begin
                    if (beat_end)
                    begin
                        state_q <= ST_IDLE;
                        ready_q <= 1'b0;
                    end
                    if (accept)
                        first_q <= 1'b0;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    ready_q <= 1'b0;
                end
            endcase
        end
    end

    // packet kind and sticky abort and valid-drop state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            payload_q <= 1'b0;
            abort_q <= 1'b0;
            drop_err_q <= 1'b0;
        end
        else if (beat_end)
        begin
            abort_q <= 1'b0;
            drop_err_q <= 1'b0;
        end
        else
        begin
            if (accept && first_q)
                payload_q <= has_payload;
            if (disc_now && (first_q ? has_payload : payload_q))
                abort_q <= 1'b1;
            if (state_q == ST_BODY && !first_q && !request_stream_valid)
                drop_err_q <= 1'b1;
        end
    end

    // forward each accepted beat to the link side
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link_valid <= 1'b0;
            link_data <= '0;
            link_dword_keep <= '0;
            link_final_beat <= 1'b0;
            link_nullify <= 1'b0;
        end
        else
        begin
            link_valid <= accept;
            link_final_beat <= beat_end;
            link_nullify <= beat_end && kill_now;
            if (accept)
            begin
                link_data <= request_stream_data;
                link_dword_keep <= request_stream_dword_keep;
            end
        end
    end

    // first-beat byte masks and payload offset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link_first_dword_byte_mask <= MASK_NONE;
            link_last_dword_byte_mask <= MASK_NONE;
            link_payload_offset <= 3'h0;
        end
        else if (accept && first_q)
        begin
            if (is_msg)
            begin
                link_first_dword_byte_mask <= MASK_NONE;
                link_last_dword_byte_mask <= MASK_NONE;
            end
            else if (is_atomic)
            begin
                link_first_dword_byte_mask <= MASK_ALL;
                link_last_dword_byte_mask <= MASK_ALL;
            end
            else
            begin
                link_first_dword_byte_mask <= request_sideband_bus[FIRST_MASK_LSB +: 4];
                link_last_dword_byte_mask <= request_sideband_bus[LAST_MASK_LSB +: 4];
            end
            if (ctrl_q[CTRL_ADDR_ALIGN_BIT] && !is_msg)
                link_payload_offset <= request_sideband_bus[OFFSET_LSB +: 3];
            else
                link_payload_offset <= 3'h0;
        end
    end

    // error report toward the root complex, endpoint only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            aer_internal_error <= 1'b0;
        else
            aer_internal_error <= beat_end && kill_now && ctrl_q[CTRL_ENDPOINT_BIT];
    end

    // malformed payload-free request flag and nullified packet count
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_err_q <= 1'b0;
            null_cnt_q <= NULL_CNT_RESET;
        end
        else
        begin
            if (accept && first_q && !has_payload && !request_stream_final_beat)
                frame_err_q <= 1'b1;
            else if (wr_pend_q && wr_addr_q == ADDR_STATUS && hwdata[STATUS_FRAME_ERR_BIT])
                frame_err_q <= 1'b0;
            if (beat_end && kill_now)
                null_cnt_q <= null_cnt_q + 16'h0001;
        end
    end

    // tag table, internal allocation or external claim
    tag_table u_tags
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .alloc_req(accept && first_q && is_np && !ext_mode),
        .claim_req(accept && first_q && is_np && ext_mode),
        .claim_tag(request_stream_data[DESC_TAG_LSB +: TAG_W]),
        .release_req(cpl_final_eof_accepted),
        .release_tag(cpl_tag),
        .alloc_tag_q(assigned_tag_out),
        .alloc_valid_q(assigned_tag_valid),
        .outstanding_q(outstanding),
        .full_q(table_full)
    );

    // ahb read mux
    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (haddr[7:0] == ADDR_CTRL)
            rd_value = {29'h0000_0000, ctrl_q};
        else if (haddr[7:0] == ADDR_STATUS)
            rd_value = {14'h0000, frame_err_q, table_full, 6'h00, outstanding};
        else if (haddr[7:0] == ADDR_NULL_CNT)
            rd_value = {16'h0000, null_cnt_q};
    end

    // ahb slave: zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            ctrl_q <= CTRL_RESET;
        end
        else
        begin
            if (wr_pend_q && wr_addr_q == ADDR_CTRL)
                ctrl_q <= hwdata[2:0];
            wr_pend_q <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1])
            begin
                wr_addr_q <= haddr[7:0];
                if (!hwrite)
                    hrdata_q <= rd_value;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign request_stream_ready = ready_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_tag_single_pulse: assert property (assigned_tag_valid |=> !assigned_tag_valid)
        else $error("tag valid held longer than one cycle");
    chk_tag_per_request: assert property
        ((accept && first_q && is_np && !ext_mode) |=> assigned_tag_valid)
        else $error("no tag pulse after non-posted request");
    chk_full_holds_ready: assert property
        ((state_q == ST_IDLE && request_stream_valid && blocked) |=> !request_stream_ready)
        else $error("ready raised while table full");
    chk_abort_nullifies: assert property
        ((beat_end && disc_now && (first_q ? has_payload : payload_q))
        |=> link_nullify && link_final_beat)
        else $error("aborted packet not nullified");
    chk_abort_sticky: assert property
        ((abort_q && beat_end) |=> link_nullify)
        else $error("abort dropped before packet end");
    chk_valid_drop_null: assert property
        ((drop_err_q && beat_end) |=> link_nullify && link_final_beat)
        else $error("valid drop not nullified");
    chk_msg_mask_zero: assert property
        ((accept && first_q && is_msg) |=> link_first_dword_byte_mask == MASK_NONE
        && link_last_dword_byte_mask == MASK_NONE)
        else $error("message masks not cleared");
    chk_atomic_mask_full: assert property
        ((accept && first_q && is_atomic) |=> link_first_dword_byte_mask == MASK_ALL)
        else $error("atomic masks not forced");
    chk_aer_report: assert property
        ((beat_end && kill_now && ctrl_q[CTRL_ENDPOINT_BIT]) |=> aer_internal_error)
        else $error("abort not reported");
    chk_beat_forward: assert property
        (accept |=> link_valid && link_data == $past(request_stream_data))
        else $error("accepted beat not forwarded");

    cov_np_read: cover property (accept && first_q && req_type == REQ_MEM_RD && beat_end);
    cov_abort: cover property (abort_q ##1 link_nullify);
    cov_full_stall: cover property (state_q == ST_IDLE && request_stream_valid && blocked);
endmodule

// ### requester_request_port_pkg.sv
package requester_request_port_pkg;
    localparam int DATA_W = 256;
    localparam int KEEP_W = 8;
    localparam int SIDE_W = 16;
    localparam int TAG_W = 10;
    localparam int TABLE_DEPTH = 768;
    localparam int CNT_W = 10;
    // sideband field positions
    localparam int FIRST_MASK_LSB = 0;
    localparam int LAST_MASK_LSB = 4;
    localparam int OFFSET_LSB = 8;
    localparam int DISCONTINUE_BIT = 11;
    // descriptor field positions
    localparam int REQ_TYPE_LSB = 75;
    localparam int DESC_TAG_LSB = 96;
    // request type codes and byte mask values
    localparam logic [3:0] REQ_MEM_RD = 4'h0;
    localparam logic [3:0] REQ_MEM_WR = 4'h1;
    localparam logic [3:0] REQ_IO_RD = 4'h2;
    localparam logic [3:0] REQ_IO_WR = 4'h3;
    localparam logic [3:0] REQ_ATOM_ADD = 4'h4;
    localparam logic [3:0] REQ_ATOM_SWAP = 4'h5;
    localparam logic [3:0] REQ_ATOM_CAS = 4'h6;
    localparam logic [3:0] REQ_CFG0_RD = 4'h8;
    localparam logic [3:0] REQ_CFG0_WR = 4'h9;
    localparam logic [3:0] REQ_CFG1_RD = 4'hA;
    localparam logic [3:0] REQ_CFG1_WR = 4'hB;
    localparam logic [3:0] REQ_MSG = 4'hC;
    localparam logic [3:0] REQ_MSG_VD = 4'hD;
    localparam logic [3:0] REQ_MSG_ATS = 4'hE;
    localparam logic [3:0] MASK_ALL = 4'hF;
    localparam logic [3:0] MASK_NONE = 4'h0;
    // register map and framing states
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_NULL_CNT = 8'h08;
    localparam int CTRL_EXT_TAG_BIT = 0;
    localparam int CTRL_ADDR_ALIGN_BIT = 1;
    localparam int CTRL_ENDPOINT_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h4;
    localparam int STATUS_FULL_BIT = 16;
    localparam int STATUS_FRAME_ERR_BIT = 17;
    localparam logic [15:0] NULL_CNT_RESET = 16'h0000;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BODY = 2'b10} frame_state_t;
endpackage

// ### tag_table.sv
`timescale 1ns/1ps
module tag_table
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic alloc_req,
    input wire logic claim_req,
    input wire logic [requester_request_port_pkg::TAG_W-1:0] claim_tag,
    input wire logic release_req,
    input wire logic [requester_request_port_pkg::TAG_W-1:0] release_tag,
    output logic [requester_request_port_pkg::TAG_W-1:0] alloc_tag_q,
    output logic alloc_valid_q,
    output logic [requester_request_port_pkg::CNT_W-1:0] outstanding_q,
    output logic full_q
);
    import requester_request_port_pkg::*;

    logic [TABLE_DEPTH-1:0] busy_q;
    logic [TABLE_DEPTH-1:0] set_vec;
    logic [TAG_W-1:0] free_tag;
    logic [TAG_W-1:0] set_tag;
    logic set_any;
    logic rel_hit;
    logic [CNT_W-1:0] count_d;

    // lowest free entry of the table
    always_comb
    begin
        free_tag = '0;
        for (int i = TABLE_DEPTH - 1; i >= 0; i--)
        begin
            if (!busy_q[i])
                free_tag = TAG_W'(i);
        end
    end

    assign set_any = alloc_req | claim_req;
    assign set_tag = alloc_req ? free_tag : claim_tag;
    assign rel_hit = release_req && (32'(release_tag) < TABLE_DEPTH) && busy_q[release_tag];

    // one busy bit per table entry, set wins over release
    for (genvar g = 0; g < TABLE_DEPTH; g++)
    begin : g_entry
        assign set_vec[g] = set_any && (set_tag == TAG_W'(g));
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                busy_q[g] <= 1'b0;
            else if (set_vec[g])
                busy_q[g] <= 1'b1;
            else if (release_req && release_tag == TAG_W'(g))
                busy_q[g] <= 1'b0;
        end
    end

    // outstanding count and full flag
    always_comb
    begin
        count_d = outstanding_q;
        if (set_any && !busy_q[set_tag] && !(rel_hit && release_tag != set_tag))
            count_d = outstanding_q + CNT_W'(1);
        else if (rel_hit && !(set_any && (!busy_q[set_tag] || release_tag == set_tag)))
            count_d = outstanding_q - CNT_W'(1);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            outstanding_q <= '0;
            full_q <= 1'b0;
        end
        else
        begin
            outstanding_q <= count_d;
            full_q <= (32'(count_d) >= TABLE_DEPTH);
        end
    end

    // tag handed back one cycle after allocation, in request order
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            alloc_tag_q <= '0;
            alloc_valid_q <= 1'b0;
        end
        else
        begin
            alloc_valid_q <= alloc_req;
            if (alloc_req)
                alloc_tag_q <= free_tag;
        end
    end
endmodule

// ### user_request_source.sv
`timescale 1ns/1ps
module user_request_source
(
    input wire logic hclk,
    input wire logic request_stream_ready,
    output logic request_stream_valid,
    output logic [requester_request_port_pkg::DATA_W-1:0] request_stream_data,
    output logic [requester_request_port_pkg::KEEP_W-1:0] request_stream_dword_keep,
    output logic request_stream_final_beat,
    output logic [requester_request_port_pkg::SIDE_W-1:0] request_sideband_bus
);
    import requester_request_port_pkg::*;

    // idle stream at time zero
    initial
    begin
        request_stream_valid = 1'b0;
        request_stream_data = '0;
        request_stream_dword_keep = '0;
        request_stream_final_beat = 1'b0;
        request_sideband_bus = '0;
    end

    // one packet; abort only on beat abort_at, one idle gap before beat drop_at
    task automatic send(input logic [3:0] typ, input logic [9:0] tag, input int beats,
                        input int abort_at, input int drop_at, input logic [10:0] side);
        logic [DATA_W-1:0] d;
        @(posedge hclk);
        for (int b = 0; b < beats; b++)
        begin
            d = {8{24'hA5A5A5, 8'(b)}};
            if (b == 0)
            begin
                d[REQ_TYPE_LSB +: 4] = typ;
                d[DESC_TAG_LSB +: TAG_W] = tag;
            end
            if (b == drop_at)
            begin
                request_stream_valid <= 1'b0;
                request_stream_data <= ~request_stream_data;
                @(posedge hclk);
            end
            request_stream_valid <= 1'b1;
            request_stream_data <= d;
            request_stream_dword_keep <= 8'hFF;
            request_stream_final_beat <= (b == beats - 1);
            request_sideband_bus <= {4'h0, b == abort_at, side};
            // hold everything until ready is sampled high
            do @(posedge hclk); while (request_stream_ready !== 1'b1);
        end
        // released data and sideband show the inverse, dword keep holds its last value
        request_stream_valid <= 1'b0;
        request_stream_final_beat <= 1'b0;
        request_stream_data <= ~d;
        // discontinue stays low while valid is low
        request_sideband_bus <= ~request_sideband_bus & ~(SIDE_W'(1) << DISCONTINUE_BIT);
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    import requester_request_port_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic cpl_final_eof_accepted = 1'b0;
    logic [TAG_W-1:0] cpl_tag = '0;
    logic hready, hreadyout, hresp, vld, rdy, fin, link_valid, link_final_beat, link_nullify;
    logic [31:0] hrdata;
    logic [DATA_W-1:0] dat, link_data;
    logic [KEEP_W-1:0] keep, link_dword_keep;
    logic [SIDE_W-1:0] side;
    logic [3:0] lfm, llm;
    logic [2:0] lpo;
    logic [TAG_W-1:0] assigned_tag_out;
    logic assigned_tag_valid, aer_internal_error;
    logic [TAG_W-1:0] tags[$];
    int fail_count = 0;
    int cmp_count = 0;
    int n_beat = 0;
    int n_null = 0;
    int n_aer = 0;
    int cycles = 0;
    logic [31:0] r;

    assign hready = hreadyout;
    always #25 hclk = ~hclk;

    requester_request_port i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .request_stream_valid(vld),
        .request_stream_ready(rdy), .request_stream_data(dat), .request_stream_dword_keep(keep),
        .request_stream_final_beat(fin), .request_sideband_bus(side), .link_valid(link_valid),
        .link_data(link_data), .link_dword_keep(link_dword_keep),
        .link_final_beat(link_final_beat), .link_nullify(link_nullify),
        .link_first_dword_byte_mask(lfm), .link_last_dword_byte_mask(llm),
        .link_payload_offset(lpo), .cpl_final_eof_accepted(cpl_final_eof_accepted),
        .cpl_tag(cpl_tag), .assigned_tag_out(assigned_tag_out),
        .assigned_tag_valid(assigned_tag_valid), .aer_internal_error(aer_internal_error));

    user_request_source i_src (.hclk(hclk), .request_stream_ready(rdy),
        .request_stream_valid(vld), .request_stream_data(dat), .request_stream_dword_keep(keep),
        .request_stream_final_beat(fin), .request_sideband_bus(side));

    // link and tag monitor, plus hang guard
    always @(posedge hclk)
    begin
        if (link_valid === 1'b1)
            n_beat++;
        if (link_valid === 1'b1 && link_final_beat === 1'b1 && link_nullify === 1'b1)
            n_null++;
        if (assigned_tag_valid === 1'b1)
            tags.push_back(assigned_tag_out);
        if (aer_internal_error === 1'b1)
            n_aer++;
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            conclude();
        end
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // single AHB-Lite word transfer
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(r, exp);
    endtask

    task automatic settle;
        repeat (4) @(posedge hclk);
        #1;
    endtask

    task automatic free_tag(input logic [TAG_W-1:0] t);
        @(posedge hclk);
        cpl_tag <= t;
        cpl_final_eof_accepted <= 1'b1;
        @(posedge hclk);
        cpl_final_eof_accepted <= 1'b0;
    endtask

    task automatic free_all;
        while (tags.size() > 0)
            free_tag(tags.pop_front());
    endtask

    task automatic t_regs;
        rdchk(ADDR_CTRL, {29'h0, CTRL_RESET});
        rdchk(ADDR_STATUS, 32'h0);
        rdchk(ADDR_NULL_CNT, 32'h0);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdchk(8'h0C, 32'h0);
    endtask

    // back-to-back reads of every kind, each one beat with its own tag
    task automatic t_read;
        i_src.send(REQ_MEM_RD, 10'h0, 1, -1, -1, 11'h00F);
        i_src.send(REQ_MEM_RD, 10'h0, 1, -1, -1, 11'h000);
        i_src.send(REQ_IO_RD, 10'h0, 1, -1, -1, 11'h00F);
        i_src.send(REQ_CFG0_RD, 10'h0, 1, -1, -1, 11'h00F);
        i_src.send(REQ_CFG1_RD, 10'h0, 1, -1, -1, 11'h00F);
        settle();
        check(n_beat, 5);
        check({24'h0, link_dword_keep}, 32'hFF);
        check(tags.size(), 5);
        for (int i = 1; i < 5; i++)
            check({31'h0, tags[i] == tags[i - 1]}, 32'h0);
        rdchk(ADDR_STATUS, 32'h5);
        free_all();
        rdchk(ADDR_STATUS, 32'h0);
    endtask

    task automatic t_external;
        ahb(1'b1, ADDR_CTRL, 32'h5);
        i_src.send(REQ_MEM_RD, 10'h2A5, 1, -1, -1, 11'h00F);
        settle();
        check(tags.size(), 0);
        rdchk(ADDR_STATUS, 32'h1);
        free_tag(10'h2A5);
        rdchk(ADDR_STATUS, 32'h0);
        ahb(1'b1, ADDR_CTRL, 32'h4);
    endtask

    // sticky abort, early end, valid drop, and abort ignored on a read
    task automatic t_abort;
        i_src.send(REQ_MEM_WR, 10'h0, 4, 1, -1, 11'h0FF);
        i_src.send(REQ_MEM_WR, 10'h0, 2, 1, -1, 11'h0FF);
        i_src.send(REQ_MEM_WR, 10'h0, 3, -1, 1, 11'h0FF);
        i_src.send(REQ_MEM_WR, 10'h0, 2, -1, -1, 11'h0FF);
        i_src.send(REQ_MEM_RD, 10'h0, 1, 0, -1, 11'h00F);
        settle();
        check(n_null, 3);
        check(n_aer, 3);
        rdchk(ADDR_NULL_CNT, 32'h3);
        // a read that runs past one beat raises the frame error, write one clears it
        i_src.send(REQ_MEM_RD, 10'h0, 2, -1, -1, 11'h00F);
        settle();
        ahb(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, r[STATUS_FRAME_ERR_BIT]}, 32'h1);
        ahb(1'b1, ADDR_STATUS, 32'h0002_0000);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, r[STATUS_FRAME_ERR_BIT]}, 32'h0);
    endtask

    task automatic mask_case(input logic [3:0] typ, input logic [10:0] sd, input logic [10:0] exp);
        i_src.send(typ, 10'h0, (typ == REQ_MEM_RD) ? 1 : 2, -1, -1, sd);
        settle();
        check({21'h0, lpo, llm, lfm}, {21'h0, exp});
    endtask

    task automatic t_masks;
        ahb(1'b1, ADDR_CTRL, 32'h6);
        mask_case(REQ_MEM_WR, 11'h3C3, 11'h3C3);
        mask_case(REQ_ATOM_ADD, 11'h221, 11'h2FF);
        mask_case(REQ_IO_WR, 11'h105, 11'h105);
        mask_case(REQ_MSG, 11'h077, 11'h000);
        mask_case(REQ_MEM_RD, 11'h60F, 11'h60F);
        ahb(1'b1, ADDR_CTRL, 32'h4);
        mask_case(REQ_MEM_WR, 11'h3C3, 11'h0C3);
    endtask

    // fill the table, then a read waits while a write still passes
    task automatic t_full;
        int b0;
        free_all();
        repeat (TABLE_DEPTH) i_src.send(REQ_MEM_RD, 10'h0, 1, -1, -1, 11'h00F);
        settle();
        check(tags.size(), TABLE_DEPTH);
        rdchk(ADDR_STATUS, 32'h10300);
        b0 = n_beat;
        i_src.send(REQ_MEM_WR, 10'h0, 2, -1, -1, 11'h0FF);
        fork
            i_src.send(REQ_MEM_RD, 10'h0, 1, -1, -1, 11'h00F);
            begin
                settle();
                repeat (16) @(posedge hclk);
                #1;
                check(n_beat, b0 + 2);
                free_tag(tags[0]);
            end
        join
        settle();
        check(n_beat, b0 + 3);
    endtask

    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_read();
        t_external();
        t_abort();
        t_masks();
        t_full();
        conclude();
    end
endmodule
